// [gspa_bus_model.sv]
// Far-side model: bus devices and the controller in charge
`timescale 1ns/1ps
module gspa_bus_model (
    input wire logic sys_clk,
    input wire logic srq_out,
    input wire logic [7:0] poll_byte,
    output logic [4:0] bus_addr,
    output logic [4:0] bus_sec_addr,
    output logic [7:0] rx_data
);
    // Idle byte kept away from the cleared end-of-string value
    initial begin
        bus_addr = 5'h1F;
        bus_sec_addr = 5'h1F;
        rx_data = 8'h55;
    end
    // Present address and data lines right after an edge
    task automatic drive(input logic [4:0] a, input logic [4:0] s,
                         input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_sec_addr <= s;
        rx_data <= d;
    endtask
    // Controller takes the status byte and SRQ line during a serial poll
    task automatic sample(output logic [7:0] b, output logic s);
        @(negedge sys_clk);
        b = poll_byte;
        s = srq_out;
    endtask
endmodule

// [gspa_core.sv]
// Status, service request and addressing-mode logic with Wishbone slave
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
// Summary of operation
// - Unknown command with passing sets flag, holdoff
// - Mode 3 secondary address sets flag, holdoff
// - Trigger message while listener sets flag
// - EOI or end-of-string byte sets flag
// - Clear, or selected clear while listener, sets flag
// - Send without listener or idle write errors
// - Request flag asks for next output byte
// - Received byte flag, never in continuous
// - Lockout and remote toggles set change flags
// - Address status change sets flag
// - Lockout and remote state bits reported
// - Output DMA request while byte empty
// - Input DMA request after byte received
// - Summary is OR of unmasked status
// - Poll byte returned on bus, readable
// - Request bit drives SRQ, cleared by poll
// - Waiting flag set on request, cleared
// - Mode register decodes five addressing modes
// - Only modes ignore address registers
// - Mode 1 matches two primary addresses
// - Mode 2 matches primary and secondary
// - Mode 3 two primary addresses
// - Reading status clears its flags
// - Interrupt only for unmasked bits
module gspa_core
    import gspa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [4:0] bus_addr, // Primary address seen on bus
    input wire logic [4:0] bus_sec_addr, // Secondary address seen
    input wire logic [7:0] rx_data, // Data byte taken from bus
    output logic irq,
    output logic dma_req,
    output logic srq_out,
    output logic handshake_hold,
    output logic [7:0] poll_byte,
    output logic talk_match,
    output logic listen_match,
    output logic mode_talk_only,
    output logic mode_listen_only
);
    import gspa_pkg::*;

    // Every check below runs on the system clock and rests in reset
    default clocking dflt_cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    logic [7:0] stat1; // Sticky status 1
    logic [7:0] mask1;
    logic [2:0] stat2; // Sticky change bits
    logic [2:0] mask2;
    logic dma_out_enable;
    logic dma_in_enable;
    logic [7:0] poll_reg; // Status byte with request bit
    logic poll_waiting;
    logic [7:0] addressing_mode;
    logic [6:0] adr0;
    logic [6:0] adr1;
    logic [7:0] eos_byte;
    logic [GSPA_CT_W-1:0] ctrl;
    logic [GSPA_EV_W-1:0] ev; // Event pulses, one cycle
    logic rx_full; // Byte waiting for input DMA
    logic ob_full; // Output byte register occupied
    logic hold_cpt;
    logic hold_apt;
    logic lok_q;
    logic rem_q;
    logic [3:0] adstat_q; // Previous address status
    logic [3:0] adstat;
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic summary;
    logic [7:0] set1;
    logic [2:0] set2;
    gspa_mode_e mode;

    // Bus strobes; a word address selects one register
    assign idx = wb_adr_i[5:2];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    // Mode decode; reserved code falls back to no recognition
    always_comb begin
        unique case ({addressing_mode[GSPA_MODE_TON],
                      addressing_mode[GSPA_MODE_LON],
                      addressing_mode[1:0]})
            4'h8: mode = GSPA_M_TON;
            4'h4: mode = GSPA_M_LON;
            4'h1: mode = GSPA_M_AD1;
            4'h2: mode = GSPA_M_AD2;
            4'h3: mode = GSPA_M_AD3;
            default: mode = GSPA_M_NONE;
        endcase
    end
    assign mode_talk_only = (mode == GSPA_M_TON);
    assign mode_listen_only = (mode == GSPA_M_LON);

    // Address recognition per mode
    always_comb begin
        talk_match = 1'b0;
        listen_match = 1'b0;
        unique case (mode)
            GSPA_M_AD1, GSPA_M_AD3: begin
                talk_match = (bus_addr == adr0[4:0] && !adr0[GSPA_AD_DT]) ||
                             (bus_addr == adr1[4:0] && !adr1[GSPA_AD_DT]);
                listen_match = (bus_addr == adr0[4:0] && !adr0[GSPA_AD_DL]) ||
                               (bus_addr == adr1[4:0] && !adr1[GSPA_AD_DL]);
            end
            GSPA_M_AD2: begin
                talk_match = bus_addr == adr0[4:0] &&
                             bus_sec_addr == adr1[4:0] && !adr0[GSPA_AD_DT];
                listen_match = bus_addr == adr0[4:0] &&
                               bus_sec_addr == adr1[4:0] && !adr0[GSPA_AD_DL];
            end
            default: begin
                talk_match = 1'b0;
                listen_match = 1'b0;
            end
        endcase
    end

    // Hardware set terms for status 1
    always_comb begin
        set1 = 8'h00;
        set1[GSPA_S1_CPT] = ev[GSPA_EV_UCMD] && ctrl[GSPA_CT_PASS_EN];
        set1[GSPA_S1_APT] = ev[GSPA_EV_SEC] && mode == GSPA_M_AD3;
        set1[GSPA_S1_DET] = ev[GSPA_EV_GET] && ctrl[GSPA_CT_LADS];
        set1[GSPA_S1_END] = ev[GSPA_EV_BYTE] &&
                           (ev[GSPA_EV_EOI] || rx_data == eos_byte);
        set1[GSPA_S1_DEC] = ev[GSPA_EV_DCL] ||
                           (ev[GSPA_EV_SDC] && ctrl[GSPA_CT_LADS]);
        set1[GSPA_S1_ERR] = (ev[GSPA_EV_SENT] && ctrl[GSPA_CT_NOLSN]) ||
                           (ev[GSPA_EV_OBWR] && ctrl[GSPA_CT_SIDS]);
        set1[GSPA_S1_DO] = ev[GSPA_EV_OBDONE];
        set1[GSPA_S1_DI] = ev[GSPA_EV_BYTE] && !ctrl[GSPA_CT_CONT];
    end

    // Change detection for status 2
    assign adstat = {ctrl[GSPA_CT_TADS], ctrl[GSPA_CT_LADS],
                     ctrl[GSPA_CT_CIC], ctrl[GSPA_CT_WHICH_ADDRESS_MATCHED]};
    always_comb begin
        set2 = 3'h0;
        set2[GSPA_S2_LOCKOUT_CHANGE_FLAG] = ctrl[GSPA_CT_LOCKOUT] != lok_q;
        set2[GSPA_S2_DISTANT_CHANGE_FLAG] = ctrl[GSPA_CT_REMOTE] != rem_q;
        set2[GSPA_S2_ADDR_STATE_CHANGE_FLAG] = adstat != adstat_q;
    end

    // Previous levels for change detection
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lok_q <= 1'b0;
            rem_q <= 1'b0;
            adstat_q <= 4'h0;
        end else begin
            lok_q <= ctrl[GSPA_CT_LOCKOUT];
            rem_q <= ctrl[GSPA_CT_REMOTE];
            adstat_q <= adstat;
        end
    end

    // Sticky status; a set in the read cycle survives the clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stat1 <= 8'h00;
            stat2 <= 3'h0;
        end else begin
            if (rd && idx == GSPA_IDX_STAT1)
                stat1 <= set1;
            else
                stat1 <= stat1 | set1;
            if (rd && idx == GSPA_IDX_STAT2)
                stat2 <= set2;
            else
                stat2 <= stat2 | set2;
        end
    end

    // Summary from unmasked bits drives the interrupt with no delay
    assign summary = |(stat1 & mask1) || |(stat2 & mask2);
    assign irq = summary;

    // Software-written registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mask1 <= 8'h00;
            mask2 <= 3'h0;
            dma_out_enable <= 1'b0;
            dma_in_enable <= 1'b0;
            addressing_mode <= 8'h00;
            adr0 <= 7'h00;
            adr1 <= 7'h00;
            eos_byte <= 8'h00;
            ctrl <= '0;
        end else if (wr) begin
            unique case (idx)
                GSPA_IDX_STAT1: mask1 <= wb_dat_i[7:0];
                GSPA_IDX_STAT2: begin
                    mask2 <= wb_dat_i[2:0];
                    dma_out_enable <= wb_dat_i[GSPA_S2_DMA_OUT_ENABLE];
                    dma_in_enable <= wb_dat_i[GSPA_S2_DMA_IN_ENABLE];
                end
                GSPA_IDX_ADDR_STAT: addressing_mode <= wb_dat_i[7:0];
                GSPA_IDX_CTRL: ctrl <= wb_dat_i[GSPA_CT_W-1:0];
                GSPA_IDX_ADR0: adr0 <= wb_dat_i[6:0];
                GSPA_IDX_ADR1: adr1 <= wb_dat_i[6:0];
                GSPA_IDX_EOS: eos_byte <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Event pulses last exactly one cycle after the write
    always_ff @(posedge sys_clk) begin
        if (srst)
            ev <= '0;
        else if (wr && idx == GSPA_IDX_EVENT)
            ev <= wb_dat_i[GSPA_EV_W-1:0];
        else
            ev <= '0;
    end

    // Handshake holdoffs until the CPU qualifies the command
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_cpt <= 1'b0;
            hold_apt <= 1'b0;
        end else begin
            if (set1[GSPA_S1_CPT])
                hold_cpt <= 1'b1;
            else if (ev[GSPA_EV_VALID])
                hold_cpt <= 1'b0;
            if (set1[GSPA_S1_APT])
                hold_apt <= 1'b1;
            else if (ev[GSPA_EV_VALID] || ev[GSPA_EV_NVALID])
                hold_apt <= 1'b0;
        end
    end
    assign handshake_hold = hold_cpt || hold_apt;

    // DMA occupancy: output register full until drained, input byte held
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ob_full <= 1'b0;
            rx_full <= 1'b0;
        end else begin
            if (ev[GSPA_EV_OBWR])
                ob_full <= 1'b1;
            else if (ev[GSPA_EV_OBDONE])
                ob_full <= 1'b0;
            if (ev[GSPA_EV_BYTE])
                rx_full <= 1'b1;
            else if (rd && idx == GSPA_IDX_STAT1)
                rx_full <= 1'b0;
        end
    end
    assign dma_req = (dma_out_enable && !ob_full) ||
                     (dma_in_enable && rx_full);

    // Poll byte and request bit; the poll clears the request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            poll_reg <= 8'h00;
        end else if (wr && idx == GSPA_IDX_POLL) begin
            poll_reg <= wb_dat_i[7:0];
        end else if (ctrl[GSPA_CT_SPAS]) begin
            poll_reg[GSPA_POLL_RSV] <= 1'b0;
        end
    end
    assign poll_byte = poll_reg;
    assign srq_out = poll_reg[GSPA_POLL_RSV] && !ctrl[GSPA_CT_SPAS];

    // Waiting flag: set beats clear
    always_ff @(posedge sys_clk) begin
        if (srst)
            poll_waiting <= 1'b0;
        else if (wr && idx == GSPA_IDX_POLL && wb_dat_i[GSPA_POLL_RSV] &&
                 !poll_reg[GSPA_POLL_RSV])
            poll_waiting <= 1'b1;
        else if (ev[GSPA_EV_APRS_END])
            poll_waiting <= 1'b0;
    end

    // Read data and single-wait acknowledge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h0;
            if (rd) begin
                unique case (idx)
                    GSPA_IDX_STAT1: wb_dat_o[7:0] <= stat1;
                    GSPA_IDX_STAT2: wb_dat_o[7:0] <=
                        {summary, 1'b0, ctrl[GSPA_CT_LOCKOUT],
                         ctrl[GSPA_CT_REMOTE], 1'b0, stat2};
                    GSPA_IDX_POLL: wb_dat_o[7:0] <=
                        {poll_reg[7], poll_waiting, poll_reg[5:0]};
                    GSPA_IDX_ADDR_STAT: wb_dat_o[7:0] <=
                        {2'b00, ctrl[GSPA_CT_SPAS], 2'b00, adstat[2],
                         adstat[3], adstat[0]};
                    GSPA_IDX_CTRL: wb_dat_o[GSPA_CT_W-1:0] <= ctrl;
                    GSPA_IDX_ADR0: wb_dat_o[6:0] <= adr0;
                    GSPA_IDX_ADR1: wb_dat_o[6:0] <= adr1;
                    GSPA_IDX_EOS: wb_dat_o[7:0] <= eos_byte;
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Interrupt follows unmasked status in the same cycle
    chk_irq_summary: assert property (
        irq == (|(stat1 & mask1) || |(stat2 & mask2)))
        else $error("irq differs from masked status");
    // Masked-off status raises nothing
    chk_mask_gate: assert property (
        (mask1 == 8'h00 && mask2 == 3'h0) |-> !irq)
        else $error("irq with all masks clear");
    // Read of status 1 clears it unless a new set arrives
    chk_read_clear: assert property (
        (rd && idx == GSPA_IDX_STAT1 && set1 == 8'h00) |=> stat1 == 8'h00)
        else $error("status 1 not cleared by read");
    // Continuous listen never sets the byte flag
    chk_no_di_cont: assert property (
        (ctrl[GSPA_CT_CONT] && ev[GSPA_EV_BYTE] && !stat1[GSPA_S1_DI] &&
         !(rd && idx == GSPA_IDX_STAT1)) |=> !stat1[GSPA_S1_DI])
        else $error("byte flag set in continuous mode");
    // Request bit reaches SRQ outside the poll
    sequence s_req_set;
        wr && idx == GSPA_IDX_POLL && wb_dat_i[GSPA_POLL_RSV];
    endsequence
    chk_srq_assert: assert property (
        s_req_set ##1 !ctrl[GSPA_CT_SPAS] |-> srq_out)
        else $error("SRQ not asserted");
    chk_poll_waiting_set: assert property (
        s_req_set ##0 !poll_reg[GSPA_POLL_RSV] |=> poll_waiting)
        else $error("waiting flag not set");
    // Unknown command with passing holds the handshake
    chk_cpt_hold: assert property (
        set1[GSPA_S1_CPT] |=> handshake_hold && stat1[GSPA_S1_CPT])
        else $error("no holdoff on passed command");
    // Only-modes recognise no address
    chk_only_nomatch: assert property (
        (mode_talk_only || mode_listen_only) |-> !talk_match && !listen_match)
        else $error("address matched in only mode");
    // Output DMA request while register empty
    chk_dma_out: assert property (
        (dma_out_enable && !ob_full) |-> dma_req)
        else $error("missing output DMA request");
endmodule

// [gspa_pkg.sv]
// Package: register map, field positions and mode codes for the status block
package gspa_pkg;
    // Register offsets (byte addresses on the bus; index times four)
    localparam logic [3:0] GSPA_IDX_STAT1 = 4'h1; // Status 1 / mask 1
    localparam logic [3:0] GSPA_IDX_STAT2 = 4'h2; // Status 2 / mask 2
    localparam logic [3:0] GSPA_IDX_POLL = 4'h3; // Poll status / mode
    localparam logic [3:0] GSPA_IDX_ADDR_STAT = 4'h4; // Addr status / mode
    localparam logic [3:0] GSPA_IDX_EVENT = 4'h8; // Bus event injection
    localparam logic [3:0] GSPA_IDX_CTRL = 4'h9; // Control bits
    localparam logic [3:0] GSPA_IDX_ADR0 = 4'hA; // Address register 0
    localparam logic [3:0] GSPA_IDX_ADR1 = 4'hB; // Address register 1
    localparam logic [3:0] GSPA_IDX_EOS = 4'hC; // End-of-string byte
    // Status 1 bit positions
    localparam int GSPA_S1_CPT = 7;
    localparam int GSPA_S1_APT = 6;
    localparam int GSPA_S1_DET = 5;
    localparam int GSPA_S1_END = 4;
    localparam int GSPA_S1_DEC = 3;
    localparam int GSPA_S1_ERR = 2;
    localparam int GSPA_S1_DO = 1;
    localparam int GSPA_S1_DI = 0;
    // Status 2 bit positions
    localparam int GSPA_S2_INT = 7;
    localparam int GSPA_S2_LOK = 5;
    localparam int GSPA_S2_REM = 4;
    localparam int GSPA_S2_DMA_OUT_ENABLE = 5;
    localparam int GSPA_S2_DMA_IN_ENABLE = 4;
    localparam int GSPA_S2_LOCKOUT_CHANGE_FLAG = 2;
    localparam int GSPA_S2_DISTANT_CHANGE_FLAG = 1;
    localparam int GSPA_S2_ADDR_STATE_CHANGE_FLAG = 0;
    // Poll register: request bit / waiting bit
    localparam int GSPA_POLL_RSV = 6;
    // Mode register fields
    localparam int GSPA_MODE_TON = 7;
    localparam int GSPA_MODE_LON = 6;
    // Event register bit positions (one-cycle pulses written by software)
    localparam int GSPA_EV_BYTE = 0; // Data byte taken
    localparam int GSPA_EV_EOI = 1; // Byte carried EOI
    localparam int GSPA_EV_GET = 2; // Trigger message
    localparam int GSPA_EV_DCL = 3; // Universal clear
    localparam int GSPA_EV_SDC = 4; // Selected clear
    localparam int GSPA_EV_UCMD = 5; // Unknown command
    localparam int GSPA_EV_SEC = 6; // Secondary address
    localparam int GSPA_EV_VALID = 7; // CPU valid command
    localparam int GSPA_EV_NVALID = 8; // CPU not-valid command
    localparam int GSPA_EV_SENT = 9; // Byte sent to bus
    localparam int GSPA_EV_OBWR = 10; // Output byte written
    localparam int GSPA_EV_OBDONE = 11; // Output byte drained
    localparam int GSPA_EV_APRS_END = 12; // Poll left APRS
    localparam int GSPA_EV_W = 13;
    // Control register bit positions (levels)
    localparam int GSPA_CT_PASS_EN = 0; // Unknown-command passing
    localparam int GSPA_CT_LADS = 1; // Listener addressed
    localparam int GSPA_CT_TADS = 2; // Talker addressed
    localparam int GSPA_CT_CIC = 3; // In charge
    localparam int GSPA_CT_SIDS = 4; // Source idle
    localparam int GSPA_CT_NOLSN = 5; // No listener on bus
    localparam int GSPA_CT_CONT = 6; // Continuous listen
    localparam int GSPA_CT_SPAS = 7; // Serial poll active
    localparam int GSPA_CT_LOCKOUT = 8; // Local lockout held
    localparam int GSPA_CT_REMOTE = 9; // Remote state held
    localparam int GSPA_CT_WHICH_ADDRESS_MATCHED = 10; // Second address matched
    localparam int GSPA_CT_W = 11;
    // Address register fields: bits 4:0 address, 5 listen off, 6 talk off
    localparam int GSPA_AD_DL = 5;
    localparam int GSPA_AD_DT = 6;
    // Decoded addressing modes
    typedef enum logic [2:0] {
        GSPA_M_NONE, GSPA_M_TON, GSPA_M_LON, GSPA_M_AD1, GSPA_M_AD2, GSPA_M_AD3
    } gspa_mode_e;
endpackage

// [tb.sv]
// Self-checking bench for the status and addressing block
`timescale 1ns/1ps
module tb;
    import gspa_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [5:0] wb_adr = 6'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0, wb_dat_o;
    logic wb_ack_o, irq, dma_req, srq_out, handshake_hold, sq;
    logic talk_match, listen_match, mode_talk_only, mode_listen_only;
    logic [7:0] poll_byte, rx_data, pb;
    logic [4:0] bus_addr, bus_sec_addr;
    int n_mismatch = 0;
    int cmp_count = 0;

    // 50 ns period clock
    always #25 sys_clk = ~sys_clk;

    gspa_core uut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .bus_addr(bus_addr),
        .bus_sec_addr(bus_sec_addr), .rx_data(rx_data), .irq(irq),
        .dma_req(dma_req), .srq_out(srq_out),
        .handshake_hold(handshake_hold), .poll_byte(poll_byte),
        .talk_match(talk_match), .listen_match(listen_match),
        .mode_talk_only(mode_talk_only),
        .mode_listen_only(mode_listen_only));

    gspa_bus_model bus (.sys_clk(sys_clk), .srq_out(srq_out),
        .poll_byte(poll_byte), .bus_addr(bus_addr),
        .bus_sec_addr(bus_sec_addr), .rx_data(rx_data));

    // Verdict, reached from the main flow or a stalled handshake
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic cycle; ack and data taken at the edge that sees ack
    task automatic xfer(input logic we, input logic [3:0] idx,
                        input logic [12:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'hF;
        wb_dat <= {19'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        // Stalled slave counts as a failure
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, idx, {5'h00, d}, q);
    endtask

    task automatic rd(input string what, input logic [3:0] idx,
                      input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, idx, 13'h0000, q);
        chk(what, q, exp);
    endtask

    // Event writes carry 13 bits, so they bypass the byte task
    task automatic ev(input logic [12:0] e);
        logic [7:0] q;
        xfer(1'b1, GSPA_IDX_EVENT, e, q);
    endtask

    // Control levels are 11 bits wide
    task automatic ctl(input logic [10:0] c);
        logic [7:0] q;
        xfer(1'b1, GSPA_IDX_CTRL, {2'b00, c}, q);
    endtask

    // Let edge updates land before looking at outputs
    task automatic look();
        @(negedge sys_clk);
    endtask

    // One bus event under given levels, then read and read-clear
    task automatic run_ev(input logic [10:0] c, input logic [12:0] e,
                          input logic [7:0] exp, input logic hold);
        ctl(c);
        ev(e);
        look();
        chk("hold", {7'h0, handshake_hold}, {7'h0, hold});
        chk("irq masked", {7'h0, irq}, 8'h00);
        rd("stat1", GSPA_IDX_STAT1, exp);
        rd("stat1 cleared", GSPA_IDX_STAT1, 8'h00);
    endtask

    // Mode decode and address match for one bus address
    task automatic am(input logic [7:0] m, input logic [4:0] a,
                      input logic [4:0] s, input logic t, input logic l);
        bus.drive(a, s, 8'h55);
        wr(GSPA_IDX_ADDR_STAT, m);
        look();
        chk("talk", {7'h0, talk_match}, {7'h0, t});
        chk("listen", {7'h0, listen_match}, {7'h0, l});
        chk("ton", {7'h0, mode_talk_only}, {7'h0, m == 8'h80});
        chk("lon", {7'h0, mode_listen_only}, {7'h0, m == 8'h40});
    endtask

    initial begin
        int i;
        logic [10:0] addr_state_change_flag_src [3];
        addr_state_change_flag_src = '{11'h004, 11'h008, 11'h400};
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset state and an unmapped index
        look();
        chk("irq rst", {7'h0, irq}, 8'h00);
        chk("srq rst", {7'h0, srq_out}, 8'h00);
        rd("stat2 rst", GSPA_IDX_STAT2, 8'h00);
        rd("poll rst", GSPA_IDX_POLL, 8'h00);
        rd("unmapped", 4'h5, 8'h00);
        $display("test reset done");
        // Status flag sources
        run_ev(11'h001, 13'h0020, 8'h80, 1'b1);
        ev(13'h0080);
        look();
        chk("hold valid", {7'h0, handshake_hold}, 8'h00);
        run_ev(11'h000, 13'h0020, 8'h00, 1'b0);
        wr(GSPA_IDX_ADDR_STAT, 8'h03);
        run_ev(11'h000, 13'h0040, 8'h40, 1'b1);
        ev(13'h0100);
        look();
        chk("hold notvalid", {7'h0, handshake_hold}, 8'h00);
        wr(GSPA_IDX_ADDR_STAT, 8'h01);
        run_ev(11'h000, 13'h0040, 8'h00, 1'b0);
        run_ev(11'h002, 13'h0004, 8'h20, 1'b0);
        run_ev(11'h000, 13'h0004, 8'h00, 1'b0);
        run_ev(11'h000, 13'h0003, 8'h11, 1'b0);
        run_ev(11'h000, 13'h0008, 8'h08, 1'b0);
        run_ev(11'h002, 13'h0010, 8'h08, 1'b0);
        run_ev(11'h000, 13'h0010, 8'h00, 1'b0);
        run_ev(11'h020, 13'h0200, 8'h04, 1'b0);
        run_ev(11'h010, 13'h0400, 8'h04, 1'b0);
        run_ev(11'h000, 13'h0800, 8'h02, 1'b0);
        run_ev(11'h040, 13'h0001, 8'h00, 1'b0);
        wr(GSPA_IDX_EOS, 8'h0A);
        bus.drive(5'h1F, 5'h1F, 8'h0A);
        run_ev(11'h000, 13'h0001, 8'h11, 1'b0);
        bus.drive(5'h1F, 5'h1F, 8'h55);
        $display("test status flags done");
        // Summary and masking
        wr(GSPA_IDX_STAT1, 8'h20);
        run_ev(11'h000, 13'h0008, 8'h08, 1'b0);
        ctl(11'h002);
        ev(13'h0004);
        look();
        chk("irq on", {7'h0, irq}, 8'h01);
        rd("stat1 det", GSPA_IDX_STAT1, 8'h20);
        look();
        chk("irq off", {7'h0, irq}, 8'h00);
        wr(GSPA_IDX_STAT1, 8'h00);
        $display("test summary done");
        // Remote, lockout and address state changes
        wr(GSPA_IDX_STAT2, 8'h01);
        ctl(11'h000);
        rd("stat2 pre", GSPA_IDX_STAT2, 8'h81);
        ctl(11'h100);
        rd("stat2 lok", GSPA_IDX_STAT2, 8'h24);
        ctl(11'h300);
        rd("stat2 rem", GSPA_IDX_STAT2, 8'h32);
        rd("stat2 held", GSPA_IDX_STAT2, 8'h30);
        ctl(11'h302);
        look();
        chk("irq addr_state_change_flag", {7'h0, irq}, 8'h01);
        rd("addr stat", GSPA_IDX_ADDR_STAT, 8'h04);
        rd("stat2 addr_state_change_flag", GSPA_IDX_STAT2, 8'hB1);
        ctl(11'h002);
        rd("stat2 drop", GSPA_IDX_STAT2, 8'h06);
        for (i = 0; i < 3; i++) begin
            ctl(11'h002 | addr_state_change_flag_src[i]);
            rd("stat2 src", GSPA_IDX_STAT2, 8'h81);
            ctl(11'h002);
            rd("stat2 back", GSPA_IDX_STAT2, 8'h81);
        end
        $display("test remote state done");
        // DMA requests
        wr(GSPA_IDX_STAT2, 8'h20);
        look();
        chk("dma out", {7'h0, dma_req}, 8'h01);
        ev(13'h0400);
        look();
        chk("dma full", {7'h0, dma_req}, 8'h00);
        ev(13'h0800);
        look();
        chk("dma empty", {7'h0, dma_req}, 8'h01);
        wr(GSPA_IDX_STAT2, 8'h10);
        look();
        chk("dma in idle", {7'h0, dma_req}, 8'h00);
        ev(13'h0001);
        look();
        chk("dma in", {7'h0, dma_req}, 8'h01);
        rd("stat1 dma", GSPA_IDX_STAT1, 8'h03);
        look();
        chk("dma in clr", {7'h0, dma_req}, 8'h00);
        wr(GSPA_IDX_STAT2, 8'h00);
        $display("test dma done");
        // Service request and serial poll
        ctl(11'h000);
        wr(GSPA_IDX_POLL, 8'hC5);
        look();
        chk("srq", {7'h0, srq_out}, 8'h01);
        chk("poll byte", poll_byte, 8'hC5);
        rd("poll rd", GSPA_IDX_POLL, 8'hC5);
        ctl(11'h080);
        look();
        chk("srq poll", {7'h0, srq_out}, 8'h00);
        bus.sample(pb, sq);
        chk("polled", pb, 8'h85);
        chk("srq at poll", {7'h0, sq}, 8'h00);
        rd("poll poll_waiting", GSPA_IDX_POLL, 8'hC5);
        ev(13'h1000);
        rd("poll served", GSPA_IDX_POLL, 8'h85);
        ctl(11'h000);
        $display("test serial poll done");
        // Addressing modes
        wr(GSPA_IDX_ADR0, 8'h05);
        wr(GSPA_IDX_ADR1, 8'h4A);
        am(8'h01, 5'h05, 5'h00, 1'b1, 1'b1);
        am(8'h01, 5'h0A, 5'h00, 1'b0, 1'b1);
        am(8'h01, 5'h03, 5'h00, 1'b0, 1'b0);
        am(8'h03, 5'h0A, 5'h00, 1'b0, 1'b1);
        am(8'h03, 5'h05, 5'h00, 1'b1, 1'b1);
        am(8'h02, 5'h05, 5'h0A, 1'b1, 1'b1);
        am(8'h02, 5'h05, 5'h03, 1'b0, 1'b0);
        am(8'h02, 5'h0A, 5'h0A, 1'b0, 1'b0);
        am(8'h80, 5'h05, 5'h00, 1'b0, 1'b0);
        am(8'h40, 5'h05, 5'h00, 1'b0, 1'b0);
        $display("test addressing done");
        end_sim();
    end
endmodule
